// *** src/ssp_port.sv ***
`timescale 1ns/1ns
module ssp_port (
	input  wire logic                  ref_clk,   // 25 MHz system clock
	input  wire logic                  sys_rst,   // asynchronous reset, active high
	input  wire logic                  clk_en,    // freezes all state while low
	input  wire logic [7:0]            reg_addr,  // register address
	input  wire logic [7:0]            reg_wdata, // register write data
	input  wire logic                  reg_wr,    // write strobe
	input  wire logic                  reg_rd,    // read strobe
	output logic      [7:0]            reg_rdata, // read data, cycle after the read strobe
	input  wire ssp_pkg::ssp_pins_in_s pin_in,    // serial pin levels
	output ssp_pkg::ssp_pins_out_s     pin_out,   // serial pin drive and enables
	output logic                       irq        // serial interrupt request
);

	logic [3:0]          sync_vec;
	logic                sck_s, mosi_s, miso_s, ss_s;
	logic [7:0]          ctl_reg, ctl_next, interrupt_enable_second_reg, interrupt_enable_second_next, ien2_reg, ien2_next;
	logic [7:0]          od_reg, od_next, dir_reg, dir_next;
	logic [7:0]          shift_reg, shift_next, rx_reg, rx_next, rdata_next;
	logic                latch_reg, latch_next;
	logic [3:0]          edge_cnt_reg, edge_cnt_next;
	logic [6:0]          div_cnt_reg, div_cnt_next;
	ssp_pkg::ssp_state_e state_reg, state_next;
	logic                done_reg, done_next, write_collision_flag_reg, write_collision_flag_next;
	logic                select_error_flag_reg, select_error_flag_next, mode_fault_flag_reg, mode_fault_flag_next;
	logic                armed_reg, armed_next, desel_reg, desel_next;
	logic                sck_prev_reg, sck_lvl_reg, sck_lvl_next;
	ssp_pkg::ssp_pins_out_s pins_next;
	logic                irq_next;
	logic                en, master, cpha, sel_ignore, slave_sel, sck_edge;
	logic                data_wr, start, edge_go, sample_edge, din, bit_in;
	logic [2:0]          div_code;
	logic [7:0]          byte_in;

	ssp_sync #(
		.WIDTH (4)
	) u_sync (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.async_in ({pin_in.sck, pin_in.mosi, pin_in.miso, pin_in.ss_n}),
		.sync_out (sync_vec)
	);

	assign {sck_s, mosi_s, miso_s, ss_s} = sync_vec;

	// Returns {out, oe}; an open-drain pin only ever pulls low.
	function automatic logic [1:0] pin_drive(input logic value, input logic oe, input logic od);
		return od ? {1'b0, oe & ~value} : {value, oe};
	endfunction : pin_drive

	always_comb begin
		ctl_next      = ctl_reg;
		interrupt_enable_second_next     = interrupt_enable_second_reg;
		ien2_next     = ien2_reg;
		od_next       = od_reg;
		dir_next      = dir_reg;
		shift_next    = shift_reg;
		rx_next       = rx_reg;
		latch_next    = latch_reg;
		edge_cnt_next = edge_cnt_reg;
		div_cnt_next  = div_cnt_reg;
		state_next    = state_reg;
		done_next     = done_reg;
		write_collision_flag_next     = write_collision_flag_reg;
		select_error_flag_next    = select_error_flag_reg;
		mode_fault_flag_next     = mode_fault_flag_reg;
		armed_next    = armed_reg;
		desel_next    = desel_reg;
		sck_lvl_next  = sck_lvl_reg;
		rdata_next    = 8'h00;
		edge_go       = 1'b0;
		start         = 1'b0;
		en          = ctl_reg[ssp_pkg::CTL_ENABLE];
		master      = ctl_reg[ssp_pkg::CTL_MASTER];
		cpha        = ctl_reg[ssp_pkg::CTL_CPHA];
		div_code    = {ctl_reg[ssp_pkg::CTL_DIV_HIGH], ctl_reg[ssp_pkg::CTL_DIV_MID], ctl_reg[ssp_pkg::CTL_DIV_LOW]};
		sel_ignore  = ctl_reg[ssp_pkg::CTL_SEL_DIS] & ~cpha;
		slave_sel   = sel_ignore | ~ss_s;
		sck_edge    = sck_s ^ sck_prev_reg;
		din         = master ? miso_s : mosi_s;
		sample_edge = (edge_cnt_reg[0] == cpha);
		bit_in      = sample_edge ? din : latch_reg;
		byte_in     = {shift_reg[6:0], bit_in};
		data_wr     = reg_wr && reg_addr == ssp_pkg::ADDR_DATA && en;

		// Reads. Done, collision and mode fault flags clear only on a status read followed by a data read.
		if (reg_rd) begin
			unique case (reg_addr)
				ssp_pkg::ADDR_CONTROL:    rdata_next = ctl_reg;
				ssp_pkg::ADDR_IEN_FIRST:  rdata_next = interrupt_enable_second_reg;
				ssp_pkg::ADDR_IEN_SECOND: rdata_next = ien2_reg;
				ssp_pkg::ADDR_OPEN_DRAIN: rdata_next = od_reg;
				ssp_pkg::ADDR_DIRECTION:  rdata_next = dir_reg;
				ssp_pkg::ADDR_STATUS: begin
					if (en) begin
						rdata_next = {done_reg, write_collision_flag_reg, select_error_flag_reg, mode_fault_flag_reg, 4'h0};
						armed_next = done_reg | write_collision_flag_reg | mode_fault_flag_reg;
					end
				end
				ssp_pkg::ADDR_DATA: begin
					if (en) begin
						rdata_next = rx_reg;
						if (armed_reg) begin
							done_next  = 1'b0;
							write_collision_flag_next  = 1'b0;
							mode_fault_flag_next  = 1'b0;
							armed_next = 1'b0;
						end
					end
				end
				default: rdata_next = 8'h00;
			endcase
		end

		// Writes. The status register has no write path.
		if (reg_wr) begin
			unique case (reg_addr)
				ssp_pkg::ADDR_CONTROL:    ctl_next  = reg_wdata;
				ssp_pkg::ADDR_IEN_FIRST:  interrupt_enable_second_next = reg_wdata;
				ssp_pkg::ADDR_IEN_SECOND: ien2_next = reg_wdata;
				ssp_pkg::ADDR_OPEN_DRAIN: od_next   = reg_wdata;
				ssp_pkg::ADDR_DIRECTION:  dir_next  = reg_wdata;
				default: ;
			endcase
		end
		if (data_wr) begin
			if (state_reg != ssp_pkg::ST_IDLE) begin
				write_collision_flag_next = 1'b1;
			end else begin
				shift_next = reg_wdata;
				start      = master && div_code != ssp_pkg::DIV_RESERVED;
			end
		end

		unique case (state_reg)
			ssp_pkg::ST_IDLE: begin
				if (start) begin
					state_next    = ssp_pkg::ST_MASTER;
					edge_cnt_next = 4'h0;
					div_cnt_next  = 7'(ssp_pkg::half_period(div_code) - 7'h01);
				end else if (en && !master && slave_sel && sck_edge) begin
					if (desel_reg) begin
						select_error_flag_next = 1'b1;
					end else begin
						edge_go    = 1'b1;
						state_next = ssp_pkg::ST_SLAVE;
					end
				end
			end
			ssp_pkg::ST_MASTER: begin
				if (!ss_s && !ctl_reg[ssp_pkg::CTL_SEL_DIS]) begin
					mode_fault_flag_next     = 1'b1;
					state_next    = ssp_pkg::ST_IDLE;
					edge_cnt_next = 4'h0;
				end else if (div_cnt_reg == 7'h00) begin
					div_cnt_next = 7'(ssp_pkg::half_period(div_code) - 7'h01);
					sck_lvl_next = ~sck_lvl_reg;
					edge_go      = 1'b1;
				end else begin
					div_cnt_next = div_cnt_reg - 7'h01;
				end
			end
			ssp_pkg::ST_SLAVE: begin
				if (!slave_sel) begin
					mode_fault_flag_next     = 1'b1;
					state_next    = ssp_pkg::ST_IDLE;
					edge_cnt_next = 4'h0;
				end else if (sck_edge) begin
					edge_go = 1'b1;
				end
			end
			default: state_next = ssp_pkg::ST_IDLE;
		endcase

		// One clock edge of the byte, for either role.
		if (edge_go) begin
			if (sample_edge) begin
				latch_next = din;
			end else if (!(cpha && edge_cnt_reg == 4'h0)) begin
				shift_next = byte_in;
			end
			if (edge_cnt_reg == ssp_pkg::EDGE_COUNT_LAST) begin
				rx_next       = byte_in;
				done_next     = 1'b1;
				state_next    = ssp_pkg::ST_IDLE;
				edge_cnt_next = 4'h0;
				desel_next    = !master && !sel_ignore && !cpha;
			end else begin
				edge_cnt_next = edge_cnt_reg + 4'h1;
			end
		end
		if (ss_s) begin
			desel_next = 1'b0;
		end

		// Disabling stops every transfer and is the only clear of the select error.
		if (!ctl_next[ssp_pkg::CTL_ENABLE]) begin
			state_next    = ssp_pkg::ST_IDLE;
			edge_cnt_next = 4'h0;
			select_error_flag_next    = 1'b0;
			desel_next    = 1'b0;
			armed_next    = 1'b0;
		end
		if (state_next == ssp_pkg::ST_IDLE) begin
			sck_lvl_next = ctl_next[ssp_pkg::CTL_CPOL];
		end

		pins_next = '0;
		if (ctl_next[ssp_pkg::CTL_ENABLE]) begin
			if (ctl_next[ssp_pkg::CTL_MASTER]) begin
				{pins_next.sck_out, pins_next.sck_oe} =
					pin_drive(sck_lvl_next, dir_next[ssp_pkg::DIR_SCK], od_next[ssp_pkg::OD_CLOCK]);
				{pins_next.mosi_out, pins_next.mosi_oe} =
					pin_drive(shift_next[7], dir_next[ssp_pkg::DIR_MOSI], od_next[ssp_pkg::OD_MOSI]);
			end else begin
				{pins_next.miso_out, pins_next.miso_oe} =
					pin_drive(shift_next[7], dir_next[ssp_pkg::DIR_MISO] & slave_sel,
						od_next[ssp_pkg::OD_MISO]);
			end
		end
		irq_next = interrupt_enable_second_next[ssp_pkg::IEN_GLOBAL] && ien2_next[ssp_pkg::IEN_SERIAL]
			&& (done_next || mode_fault_flag_next);
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_reg      <= ssp_pkg::CONTROL_RESET;
			interrupt_enable_second_reg     <= ssp_pkg::OTHER_RESET;
			ien2_reg     <= ssp_pkg::OTHER_RESET;
			od_reg       <= ssp_pkg::OTHER_RESET;
			dir_reg      <= ssp_pkg::OTHER_RESET;
			shift_reg    <= ssp_pkg::DATA_RESET;
			rx_reg       <= ssp_pkg::DATA_RESET;
			latch_reg    <= 1'b0;
			edge_cnt_reg <= 4'h0;
			div_cnt_reg  <= 7'h00;
			state_reg    <= ssp_pkg::ST_IDLE;
			done_reg     <= 1'b0;
			write_collision_flag_reg     <= 1'b0;
			select_error_flag_reg    <= 1'b0;
			mode_fault_flag_reg     <= 1'b0;
			armed_reg    <= 1'b0;
			desel_reg    <= 1'b0;
			sck_prev_reg <= 1'b0;
			sck_lvl_reg  <= 1'b0;
			reg_rdata    <= 8'h00;
			pin_out      <= '0;
			irq          <= 1'b0;
		end else if (clk_en) begin
			ctl_reg      <= ctl_next;
			interrupt_enable_second_reg     <= interrupt_enable_second_next;
			ien2_reg     <= ien2_next;
			od_reg       <= od_next;
			dir_reg      <= dir_next;
			shift_reg    <= shift_next;
			rx_reg       <= rx_next;
			latch_reg    <= latch_next;
			edge_cnt_reg <= edge_cnt_next;
			div_cnt_reg  <= div_cnt_next;
			state_reg    <= state_next;
			done_reg     <= done_next;
			write_collision_flag_reg     <= write_collision_flag_next;
			select_error_flag_reg    <= select_error_flag_next;
			mode_fault_flag_reg     <= mode_fault_flag_next;
			armed_reg    <= armed_next;
			desel_reg    <= desel_next;
			sck_prev_reg <= sck_s;
			sck_lvl_reg  <= sck_lvl_next;
			reg_rdata    <= rdata_next;
			pin_out      <= pins_next;
			irq          <= irq_next;
		end
	end

	property p_reserved_no_start;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && data_wr && master && div_code == ssp_pkg::DIV_RESERVED && state_reg == ssp_pkg::ST_IDLE
		|=> state_reg == ssp_pkg::ST_IDLE;
	endproperty
	a_reserved_no_start: assert property (p_reserved_no_start) else $error("Reserved divisor started a transfer.");

	property p_blocked_read;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && reg_rd && !en && (reg_addr == ssp_pkg::ADDR_STATUS || reg_addr == ssp_pkg::ADDR_DATA)
		|=> reg_rdata == 8'h00;
	endproperty
	a_blocked_read: assert property (p_blocked_read) else $error("Disabled register returned data.");

	property p_done_from_transfer;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(done_reg) |-> $past(state_reg) != ssp_pkg::ST_IDLE && state_reg == ssp_pkg::ST_IDLE;
	endproperty
	a_done_from_transfer: assert property (p_done_from_transfer) else $error("Completion flag without a transfer.");

	property p_collision;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && data_wr && state_reg != ssp_pkg::ST_IDLE |=> write_collision_flag_reg;
	endproperty
	a_collision: assert property (p_collision) else $error("Busy data write did not flag a collision.");

	property p_select_error_flag_cleared;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && !ctl_next[ssp_pkg::CTL_ENABLE] |=> !select_error_flag_reg && state_reg == ssp_pkg::ST_IDLE;
	endproperty
	a_select_error_flag_cleared: assert property (p_select_error_flag_cleared) else $error("Disable did not clear select error.");

	property p_irq_gated;
		@(posedge ref_clk) disable iff (sys_rst)
		irq |-> interrupt_enable_second_reg[ssp_pkg::IEN_GLOBAL] && ien2_reg[ssp_pkg::IEN_SERIAL] && (done_reg || mode_fault_flag_reg);
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("Interrupt raised while gated off.");

	property p_idle_level;
		@(posedge ref_clk) disable iff (sys_rst)
		state_reg == ssp_pkg::ST_IDLE && en && master && !od_reg[ssp_pkg::OD_CLOCK] && dir_reg[ssp_pkg::DIR_SCK]
		|-> pin_out.sck_out == ctl_reg[ssp_pkg::CTL_CPOL] && pin_out.sck_oe;
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("Idle clock level differs from polarity.");

	property p_flag_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && reg_rd && reg_addr == ssp_pkg::ADDR_DATA && en && armed_reg && state_reg == ssp_pkg::ST_IDLE
		|=> !done_reg && !write_collision_flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("Status then data read left flags set.");

	property p_master_fault;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && en && ctl_next[ssp_pkg::CTL_ENABLE] && state_reg == ssp_pkg::ST_MASTER && !ss_s
		&& !ctl_reg[ssp_pkg::CTL_SEL_DIS] |=> mode_fault_flag_reg && state_reg == ssp_pkg::ST_IDLE;
	endproperty
	a_master_fault: assert property (p_master_fault) else $error("Select low in master gave no fault.");

	property p_msb_first;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && start && !od_reg[ssp_pkg::OD_MOSI] && dir_reg[ssp_pkg::DIR_MOSI]
		|=> pin_out.mosi_out == $past(reg_wdata[7]);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("First bit out is not the top bit.");

	property p_master_byte_time;
		@(posedge ref_clk) disable iff (sys_rst)
		clk_en && start && div_code == 3'h0 && ctl_reg[ssp_pkg::CTL_SEL_DIS] ##1 clk_en [*8] ##1 clk_en [*8]
		|-> ##1 (done_reg || !en);
	endproperty
	a_master_byte_time: assert property (p_master_byte_time) else $error("Fastest byte took longer than 17 cycles.");

endmodule : ssp_port

// *** src/ssp_pkg.sv ***
package ssp_pkg;

	// Register addresses.
	localparam logic [7:0] ADDR_IEN_FIRST  = 8'ha8;
	localparam logic [7:0] ADDR_IEN_SECOND = 8'hb8;
	localparam logic [7:0] ADDR_STATUS     = 8'he1;
	localparam logic [7:0] ADDR_CONTROL    = 8'he2;
	localparam logic [7:0] ADDR_DATA       = 8'he3;
	localparam logic [7:0] ADDR_OPEN_DRAIN = 8'he4;
	localparam logic [7:0] ADDR_DIRECTION  = 8'hf9;

	// Control register fields.
	localparam int CTL_DIV_HIGH = 7;
	localparam int CTL_ENABLE   = 6;
	localparam int CTL_SEL_DIS  = 5;
	localparam int CTL_MASTER   = 4;
	localparam int CTL_CPOL     = 3;
	localparam int CTL_CPHA     = 2;
	localparam int CTL_DIV_MID  = 1;
	localparam int CTL_DIV_LOW  = 0;

	// Status register fields.
	localparam int STA_DONE  = 7;
	localparam int STA_WRITE_COLLISION_FLAG  = 6;
	localparam int STA_SELECT_ERROR_FLAG = 5;
	localparam int STA_MODE_FAULT_FLAG  = 4;

	// Interrupt enable, open-drain and direction fields.
	localparam int IEN_GLOBAL = 7;
	localparam int IEN_SERIAL = 1;
	localparam int OD_CLOCK   = 4;
	localparam int OD_MOSI    = 3;
	localparam int OD_MISO    = 2;
	localparam int DIR_SCK    = 6;
	localparam int DIR_MOSI   = 5;
	localparam int DIR_MISO   = 4;

	// Values after reset.
	localparam logic [7:0] CONTROL_RESET = 8'h14;
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam logic [7:0] OTHER_RESET   = 8'h00;

	// Divisor code with no clock, and the last of the sixteen clock edges of a byte.
	localparam logic [2:0] DIV_RESERVED    = 3'h7;
	localparam logic [3:0] EDGE_COUNT_LAST = 4'hf;

	typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} ssp_state_e;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} ssp_pins_in_s;

	typedef struct packed {
		logic sck_out;
		logic sck_oe;
		logic mosi_out;
		logic mosi_oe;
		logic miso_out;
		logic miso_oe;
	} ssp_pins_out_s;

	// Half a serial clock period in ref_clk cycles for a divisor code.
	function automatic logic [6:0] half_period(input logic [2:0] code);
		return 7'(7'h01 << code);
	endfunction : half_period

endpackage : ssp_pkg

// *** src/ssp_sync.sv ***
`timescale 1ns/1ns
module ssp_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             ref_clk,  // system clock
	input  wire logic             sys_rst,  // asynchronous reset
	input  wire logic             clk_en,   // freezes the stages when low
	input  wire logic [WIDTH-1:0] async_in, // pin levels
	output logic      [WIDTH-1:0] sync_out  // levels after two stages
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_reg <= '0;
			sync_out   <= '0;
		end else if (clk_en) begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule : ssp_sync

// *** verification/ssp_slave_model.sv ***
`timescale 1ns/1ns
module ssp_slave_model (
	input  wire logic       sck,  // serial clock from the master
	input  wire logic       mosi, // data from the master
	input  wire logic       cs_n, // select, active low
	input  wire logic       cpha, // sample on the second edge when high
	input  wire logic [7:0] tx,   // byte to send
	output logic            miso, // data to the master
	output logic      [7:0] rx    // byte received
);
	logic [7:0] sh;
	int         n;
	initial begin
		miso = 1'b0;
		rx = 8'h00;
		sh = 8'h00;
		n = 0;
	end
	// A released line shows the inverse of its last level, so a late sample never reads as data.
	always @(posedge cs_n) miso = ~miso;
	always @(negedge cs_n) begin
		sh = tx;
		n = 0;
		if (!cpha) miso = tx[7];
	end
	always @(sck) begin
		if (!cs_n && n < 16) begin
			n = n + 1;
			if (n[0] != cpha) begin
				rx = {rx[6:0], mosi};
				sh = {sh[6:0], 1'b0};
			end else begin
				miso = sh[7];
			end
		end
	end
endmodule : ssp_slave_model

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
	typedef struct {logic [7:0] ctrl; logic [7:0] tx; logic [7:0] sl;} ssp_row_s;
	logic                   ref_clk;
	logic                   sys_rst;
	logic                   clk_en;
	logic [7:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [7:0]             reg_rdata;
	ssp_pkg::ssp_pins_in_s  pin_in;
	ssp_pkg::ssp_pins_out_s pin_out;
	logic                   irq;
	logic                   m_sck, m_mosi, ss_n, p_cs_n, p_cpha, cur_cpol, p_miso;
	logic [7:0]             p_tx, p_rx, st, r;
	wire                    sck_w  = pin_out.sck_oe ? pin_out.sck_out : m_sck;
	wire                    mosi_w = pin_out.mosi_oe ? pin_out.mosi_out : m_mosi;
	wire                    miso_w = pin_out.miso_oe ? pin_out.miso_out : p_miso;
	int                     fails, compares, hi_cnt, base;
	// The two fastest divisors outrun the input synchroniser, so their slave bytes keep one level.
	ssp_row_s               rows[7] = '{'{8'h70, 8'ha5, 8'hff}, '{8'h55, 8'h81, 8'hff}, '{8'h5a, 8'h0f, 8'hf0},
		'{8'h5f, 8'h55, 8'h66}, '{8'hd0, 8'h99, 8'haa}, '{8'hdd, 8'h01, 8'h80}, '{8'hd6, 8'hfe, 8'h7f}};

	assign pin_in = {sck_w, mosi_w, miso_w, ss_n};
	ssp_port i_ssp_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
		.pin_out(pin_out), .irq(irq));
	ssp_slave_model i_ssp_slave_model (.sck(sck_w), .mosi(mosi_w), .cs_n(p_cs_n), .cpha(p_cpha), .tx(p_tx),
		.miso(p_miso), .rx(p_rx));

	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	// Counts cycles with the clock away from its idle level, which gives eight half periods of the divisor per byte.
	always @(posedge ref_clk) if (sck_w !== cur_cpol) hi_cnt <= hi_cnt + 1;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd
	task automatic wait_done(output logic [7:0] s);
		int k;
		s = 8'h00;
		for (k = 0; k < 3000 && s[7] !== 1'b1; k++) rd(ssp_pkg::ADDR_STATUS, s);
	endtask : wait_done
	task automatic slv_bits(input logic [7:0] d, input int nb, output logic [7:0] q);
		int i;
		q = 8'h00;
		for (i = 7; i > 7 - nb; i--) begin
			@(posedge ref_clk);
			m_mosi <= d[i];
			m_sck <= 1'b1;
			repeat (4) @(posedge ref_clk);
			q[i] = miso_w;
			m_sck <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask : slv_bits
	task automatic complete_run;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		complete_run();
	end

	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, m_sck, m_mosi, cur_cpol} = '0;
		{sys_rst, clk_en, ss_n, p_cs_n, p_cpha} = 5'b11111;
		p_tx = 8'h00;
		fails = 0;
		compares = 0;
		hi_cnt = 0;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(ssp_pkg::ADDR_CONTROL, r);
		chk(r, ssp_pkg::CONTROL_RESET);
		wr(ssp_pkg::ADDR_DATA, 8'h77);
		rd(ssp_pkg::ADDR_DATA, r);
		chk(r, 8'h00);
		wr(ssp_pkg::ADDR_CONTROL, 8'h50);
		wr(ssp_pkg::ADDR_DIRECTION, 8'h70);
		wr(ssp_pkg::ADDR_IEN_SECOND, 8'h02);
		wr(ssp_pkg::ADDR_STATUS, 8'hff);
		rd(ssp_pkg::ADDR_STATUS, r);
		chk(r, 8'h00);
		rd(8'h00, r);
		chk(r, 8'h00);
		foreach (rows[i]) begin
			p_cs_n <= 1'b1;
			p_cpha <= rows[i].ctrl[2];
			p_tx <= rows[i].sl;
			cur_cpol <= rows[i].ctrl[3];
			wr(ssp_pkg::ADDR_CONTROL, rows[i].ctrl);
			repeat (3) @(posedge ref_clk);
			p_cs_n <= 1'b0;
			base = hi_cnt;
			wr(ssp_pkg::ADDR_DATA, rows[i].tx);
			wait_done(st);
			chk(st, 8'h80);
			chk(irq, 1'b0);
			chk(16'(hi_cnt - base), 16'(8 << {rows[i].ctrl[7], rows[i].ctrl[1:0]}));
			chk(sck_w, rows[i].ctrl[3]);
			rd(ssp_pkg::ADDR_DATA, r);
			chk(r, rows[i].sl);
			chk(p_rx, rows[i].tx);
			rd(ssp_pkg::ADDR_STATUS, r);
			chk(r, 8'h00);
		end
		p_cs_n <= 1'b1;
		p_tx <= 8'h3c;
		@(posedge ref_clk);
		p_cs_n <= 1'b0;
		wr(ssp_pkg::ADDR_DATA, 8'ha5);
		wr(ssp_pkg::ADDR_DATA, 8'h5a);
		wait_done(st);
		chk(st, 8'hc0);
		chk(p_rx, 8'ha5);
		rd(ssp_pkg::ADDR_DATA, r);
		rd(ssp_pkg::ADDR_STATUS, r);
		chk(r, 8'h00);
		p_cs_n <= 1'b1;
		cur_cpol <= 1'b0;
		wr(ssp_pkg::ADDR_CONTROL, 8'hd3);
		base = hi_cnt;
		wr(ssp_pkg::ADDR_DATA, 8'h42);
		repeat (300) @(posedge ref_clk);
		rd(ssp_pkg::ADDR_STATUS, r);
		chk(r, 8'h00);
		chk(16'(hi_cnt - base), 16'h0000);
		wr(ssp_pkg::ADDR_CONTROL, 8'h58);
		wr(ssp_pkg::ADDR_OPEN_DRAIN, 8'h1c);
		repeat (2) @(posedge ref_clk);
		chk(pin_out.sck_oe, 1'b0);
		wr(ssp_pkg::ADDR_OPEN_DRAIN, 8'h00);
		repeat (2) @(posedge ref_clk);
		chk(pin_out.sck_oe, 1'b1);
		wr(ssp_pkg::ADDR_IEN_FIRST, 8'h80);
		wr(ssp_pkg::ADDR_CONTROL, 8'hd0);
		wr(ssp_pkg::ADDR_DATA, 8'h11);
		repeat (20) @(posedge ref_clk);
		ss_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		ss_n <= 1'b1;
		rd(ssp_pkg::ADDR_STATUS, r);
		chk(r, 8'h10);
		chk(irq, 1'b1);
		rd(ssp_pkg::ADDR_DATA, r);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		wr(ssp_pkg::ADDR_IEN_FIRST, 8'h00);
		wr(ssp_pkg::ADDR_CONTROL, 8'h44);
		wr(ssp_pkg::ADDR_DATA, 8'hc3);
		ss_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		slv_bits(8'h96, 8, r);
		chk(r, 8'hc3);
		ss_n <= 1'b1;
		wait_done(st);
		chk(st, 8'h80);
		rd(ssp_pkg::ADDR_DATA, r);
		chk(r, 8'h96);
		ss_n <= 1'b0;
		slv_bits(8'h00, 4, r);
		ss_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(ssp_pkg::ADDR_STATUS, r);
		chk(r, 8'h10);
		wr(ssp_pkg::ADDR_CONTROL, 8'h14);
		rd(ssp_pkg::ADDR_STATUS, r);
		chk(r, 8'h00);
		complete_run();
	end
endmodule : tb
